/* verilog/amd_calib.sv */
// modulation depth calibration sequencer with avalon-mm register slave
//
// Added by the designer: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
`include "amd_defines.svh"
module amd_calib (
	// clock and reset
	input wire logic CORE_CLK,
	input wire logic RST,
	// avalon-mm slave
	input wire logic [4:0] ADDRESS,
	input wire logic READ,
	input wire logic WRITE,
	input wire logic [31:0] WRITEDATA,
	output logic [31:0] READDATA,
	output logic WAITREQUEST,
	// converter on the receiver sense inputs
	output logic ADC_START,
	input amd_pkg::amd_adc_t ADC_RESULT,
	// transmitter
	input wire logic MOD_REQ,
	output logic TX_ENABLE,
	output logic [7:0] ANT_CODE,
	output logic ANT_OOK_OFF
);
	import amd_pkg::*;

	function automatic logic [7:0] amd_target(input logic [7:0] m, input logic [5:0] f);
		logic [13:0] num;
		logic [13:0] den;
		num = {m, 6'h00};
		den = {7'h00, 1'b1, f};
		return 8'(num / den);
	endfunction

	// register group
	amd_depth_t depth;
	logic [7:0] ask_level;
	logic [7:0] nomod_level;
	logic [3:0] mode;
	logic cmd_cal;
	logic cmd_meas;
	amd_depth_t next_depth;
	logic [7:0] next_ask_level;
	logic [7:0] next_nomod_level;
	logic [3:0] next_mode;
	logic next_cmd_cal;
	logic next_cmd_meas;
	logic next_waitreq;
	logic [31:0] next_readdata;
	// sequencer group
	amd_state_t state;
	amd_kind_t kind;
	logic [7:0] code;
	logic [7:0] unmod;
	logic [7:0] target;
	logic [7:0] meas;
	logic [7:0] adc_reg;
	logic [7:0] result;
	logic sat;
	logic [7:0] settle;
	amd_state_t next_state;
	amd_kind_t next_kind;
	logic [7:0] next_code;
	logic [7:0] next_unmod;
	logic [7:0] next_target;
	logic [7:0] next_meas;
	logic [7:0] next_adc_reg;
	logic [7:0] next_result;
	logic next_sat;
	logic [7:0] next_settle;
	logic next_adc_start;
	// output group
	logic next_tx;
	logic [7:0] next_ant;
	logic next_ook;
	logic busy;
	logic use_ask;
	logic acc;

	assign busy = (state != S_IDLE);
	// access completes in the cycle where waitrequest is low
	assign acc = (READ | WRITE) & ~WAITREQUEST;
	assign use_ask = mode[`AMD_BIT_ISO_B] |
		(mode[`AMD_BIT_TRANSP] & mode[`AMD_BIT_ASK_TYPE]);

	always_comb begin
		next_depth = depth;
		next_ask_level = ask_level;
		next_nomod_level = nomod_level;
		next_mode = mode;
		next_cmd_cal = 1'b0;
		next_cmd_meas = 1'b0;
		// fixed two-cycle answer keeps the slave free of combinational paths
		next_waitreq = ~((READ | WRITE) & WAITREQUEST);
		next_readdata = READDATA;
		if ((READ | WRITE) & WAITREQUEST) begin
			case (ADDRESS)
				`AMD_OFF_TARGET: next_readdata = {24'h000000, depth};
				`AMD_OFF_ASK_LEVEL: next_readdata = {24'h000000, ask_level};
				`AMD_OFF_NOMOD_LEVEL: next_readdata = {24'h000000, nomod_level};
				`AMD_OFF_MODE: next_readdata = {28'h0000000, mode};
				`AMD_OFF_ADC: next_readdata = {24'h000000, adc_reg};
				`AMD_OFF_RESULT: next_readdata = {24'h000000, result};
				`AMD_OFF_STATUS: next_readdata = {29'h00000000,
					(depth.frac > `AMD_FRAC_MAX_30PCT), sat, busy};
				default: next_readdata = `AMD_UNMAPPED;
			endcase
		end
		if (acc & WRITE) begin
			case (ADDRESS)
				`AMD_OFF_TARGET: next_depth = amd_depth_t'(WRITEDATA[7:0]);
				`AMD_OFF_ASK_LEVEL: next_ask_level = WRITEDATA[7:0];
				`AMD_OFF_NOMOD_LEVEL: next_nomod_level = WRITEDATA[7:0];
				`AMD_OFF_MODE: next_mode = WRITEDATA[3:0];
				`AMD_OFF_CMD: begin
					next_cmd_cal = WRITEDATA[`AMD_BIT_CMD_CAL];
					next_cmd_meas = WRITEDATA[`AMD_BIT_CMD_MEAS];
				end
				default: next_mode = mode;
			endcase
		end
	end

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			depth <= amd_depth_t'(`AMD_RST_TARGET);
			ask_level <= `AMD_RST_ASK_LEVEL;
			nomod_level <= `AMD_RST_NOMOD_LEVEL;
			mode <= `AMD_RST_MODE;
			cmd_cal <= 1'b0;
			cmd_meas <= 1'b0;
			WAITREQUEST <= 1'b1;
			READDATA <= 32'h00000000;
		end else begin
			depth <= next_depth;
			ask_level <= next_ask_level;
			nomod_level <= next_nomod_level;
			mode <= next_mode;
			cmd_cal <= next_cmd_cal;
			cmd_meas <= next_cmd_meas;
			WAITREQUEST <= next_waitreq;
			READDATA <= next_readdata;
		end
	end

	// commands arriving while busy are dropped; oscillator is assumed running
	always_comb begin
		next_state = state;
		next_kind = kind;
		next_code = code;
		next_unmod = unmod;
		next_target = target;
		next_meas = meas;
		next_adc_reg = adc_reg;
		next_result = result;
		next_sat = sat;
		next_settle = settle;
		next_adc_start = 1'b0;
		case (state)
			S_IDLE: begin
				next_settle = 8'(`AMD_SETTLE_CYC);
				if (cmd_cal) begin
					next_kind = K_UNMOD;
					next_code = nomod_level;
					next_sat = 1'b0;
					next_state = S_SETTLE;
				end else if (cmd_meas) begin
					next_kind = K_RF;
					next_state = S_SETTLE;
				end
			end
			S_SETTLE: begin
				next_settle = settle - 8'h01;
				if (settle == 8'h01) begin
					next_adc_start = 1'b1;
					next_state = S_WAIT;
				end
			end
			S_WAIT: begin
				if (ADC_RESULT.done) begin
					next_adc_reg = ADC_RESULT.data;
					case (kind)
						K_UNMOD: begin
							next_unmod = ADC_RESULT.data;
							next_state = S_CALC;
						end
						K_STEP: begin
							next_meas = ADC_RESULT.data;
							next_state = S_CMP;
						end
						default: next_state = S_IDLE;
					endcase
				end
			end
			S_CALC: begin
				next_target = amd_target(unmod, depth.frac);
				next_state = S_STEP;
			end
			S_STEP: begin
				if (code == `AMD_CODE_MAX) begin
					next_result = code;
					next_sat = 1'b1;
					next_state = S_IDLE;
				end else begin
					next_code = code + 8'h01;
					next_kind = K_STEP;
					next_settle = 8'(`AMD_SETTLE_CYC);
					next_state = S_SETTLE;
				end
			end
			S_CMP: begin
				if (meas > target) begin
					next_state = S_STEP;
				end else begin
					next_result = code;
					next_state = S_IDLE;
				end
			end
			default: next_state = S_IDLE;
		endcase
	end

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			state <= S_IDLE;
			kind <= K_UNMOD;
			code <= 8'h00;
			unmod <= 8'h00;
			target <= 8'h00;
			meas <= 8'h00;
			adc_reg <= 8'h00;
			result <= 8'h00;
			sat <= 1'b0;
			settle <= 8'h00;
			ADC_START <= 1'b0;
		end else begin
			state <= next_state;
			kind <= next_kind;
			code <= next_code;
			unmod <= next_unmod;
			target <= next_target;
			meas <= next_meas;
			adc_reg <= next_adc_reg;
			result <= next_result;
			sat <= next_sat;
			settle <= next_settle;
			ADC_START <= next_adc_start;
		end
	end

	// driver code: higher value switches off more segments
	always_comb begin
		next_tx = mode[`AMD_BIT_TX_EN] | (busy & kind != K_RF);
		next_ook = 1'b0;
		next_ant = nomod_level;
		if (busy && kind != K_RF) begin
			next_ant = code;
		end else if (MOD_REQ && use_ask) begin
			next_ant = depth.src_sel ? ask_level : result;
		end else if (MOD_REQ) begin
			next_ook = 1'b1;
		end
	end

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			TX_ENABLE <= 1'b0;
			ANT_CODE <= `AMD_RST_NOMOD_LEVEL;
			ANT_OOK_OFF <= 1'b0;
		end else begin
			TX_ENABLE <= next_tx;
			ANT_CODE <= next_ant;
			ANT_OOK_OFF <= next_ook;
		end
	end

	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (RST);

	sequence req_seen;
		(READ | WRITE) && WAITREQUEST;
	endsequence
	sequence answer_pulse;
		!WAITREQUEST ##1 WAITREQUEST;
	endsequence

	a_bus_answer_time: assert property (req_seen |=> answer_pulse)
		else $error("waitrequest did not pulse low for one cycle");
	a_ook_no_ask: assert property (state == S_IDLE && MOD_REQ && !use_ask |=> ANT_OOK_OFF)
		else $error("on-off keying not used outside keyed modes");
	a_host_level_used: assert property (state == S_IDLE && MOD_REQ && use_ask
		&& depth.src_sel |=> ANT_CODE == $past(ask_level))
		else $error("host keyed level not applied");
	a_calib_level_used: assert property (state == S_IDLE && MOD_REQ && use_ask
		&& !depth.src_sel |=> ANT_CODE == $past(result))
		else $error("calibrated level not applied");
	a_unmod_store: assert property (state == S_WAIT && kind == K_UNMOD
		&& ADC_RESULT.done |=> unmod == $past(ADC_RESULT.data) ##1 state == S_STEP)
		else $error("unmodulated measurement not stored");
	a_target_calc: assert property (state == S_CALC
		|=> target == amd_target($past(unmod), $past(depth.frac)))
		else $error("target level wrong");
	a_step_inc: assert property (state == S_STEP && code != `AMD_CODE_MAX
		|=> code == $past(code) + 8'h01 && state == S_SETTLE)
		else $error("code did not step by one");
	a_keep_stepping: assert property (state == S_CMP && meas > target |=> state == S_STEP)
		else $error("stopped while still above target");
	a_latch_hit: assert property (state == S_CMP && meas <= target
		|=> result == $past(code) && state == S_IDLE)
		else $error("result not latched at target");
	a_saturate: assert property (state == S_STEP && code == `AMD_CODE_MAX
		|=> sat && result == `AMD_CODE_MAX ##1 !busy)
		else $error("saturation not handled");
	a_tx_during_cal: assert property (busy && kind != K_RF |=> TX_ENABLE)
		else $error("transmitter off during calibration");
endmodule // amd_calib

/* verilog/amd_defines.svh */
// register map, field positions, reset values and timing counts
`ifndef AMD_DEFINES_SVH
`define AMD_DEFINES_SVH
`define AMD_OFF_TARGET 5'h00
`define AMD_OFF_ASK_LEVEL 5'h04
`define AMD_OFF_NOMOD_LEVEL 5'h08
`define AMD_OFF_MODE 5'h0c
`define AMD_OFF_CMD 5'h10
`define AMD_OFF_ADC 5'h14
`define AMD_OFF_RESULT 5'h18
`define AMD_OFF_STATUS 5'h1c
`define AMD_BIT_SRC_SEL 7
`define AMD_BIT_ISO_B 0
`define AMD_BIT_TRANSP 1
`define AMD_BIT_ASK_TYPE 2
`define AMD_BIT_TX_EN 3
`define AMD_BIT_CMD_CAL 0
`define AMD_BIT_CMD_MEAS 1
`define AMD_RST_TARGET 8'h00
`define AMD_RST_ASK_LEVEL 8'h00
`define AMD_RST_NOMOD_LEVEL 8'h00
`define AMD_RST_MODE 4'h0
`define AMD_FRAC_MAX_30PCT 6'h37
`define AMD_CODE_MAX 8'hff
`define AMD_UNMAPPED 32'h00000000
`define AMD_CLK_MHZ 100
`define AMD_SETTLE_NS 1000
`define AMD_SETTLE_CYC ((`AMD_SETTLE_NS * `AMD_CLK_MHZ + 999) / 1000)
`endif

/* verilog/amd_pkg.sv */
// types shared by the modulation depth calibration block
package amd_pkg;
	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_SETTLE = 3'b001,
		S_WAIT = 3'b010,
		S_CALC = 3'b011,
		S_STEP = 3'b100,
		S_CMP = 3'b101
	} amd_state_t;
	typedef enum logic [1:0] {
		K_UNMOD = 2'b00,
		K_STEP = 2'b01,
		K_RF = 2'b10
	} amd_kind_t;
	typedef struct packed {
		logic done;
		logic [7:0] data;
	} amd_adc_t;
	typedef struct packed {
		logic src_sel;
		logic [5:0] frac;
		logic spare;
	} amd_depth_t;
endpackage

/* dv/amd_adc_model.sv */
// converter and antenna model answering carrier conversions
`timescale 1ns/1ps
module amd_adc_model (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// conversion handshake and driver code
	input wire logic start,
	input wire logic [7:0] code,
	input wire logic slow,
	input wire logic [7:0] floor_lvl,
	output amd_pkg::amd_adc_t result
);
	import amd_pkg::*;
	logic [3:0] cnt;
	logic [7:0] last;
	int v;
	// more resistance per code step lowers the sensed carrier
	always_comb v = (200 - 4 * int'(code) < int'(floor_lvl)) ? floor_lvl : 200 - 4 * code;
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt <= 4'h0;
			last <= 8'h00;
			result <= '0;
		end else begin
			result.done <= 1'b0;
			// released data lines carry the inverse of the last converted value
			result.data <= ~last;
			if (start) begin
				cnt <= slow ? 4'h6 : 4'h1;
			end else if (cnt == 4'h1) begin
				result.done <= 1'b1;
				result.data <= v[7:0];
				last <= v[7:0];
				cnt <= 4'h0;
			end else if (cnt != 4'h0) begin
				cnt <= cnt - 4'h1;
			end
		end
	end
endmodule // amd_adc_model

/* dv/tb_amd_calib.sv */
// self-checking bench for the modulation depth calibration block
`timescale 1ns/1ps
`include "amd_defines.svh"
module tb_amd_calib;
	import amd_pkg::*;
	logic CORE_CLK, RST, READ, WRITE, MOD_REQ, ADC_START, TX_ENABLE, WAITREQUEST, ANT_OOK_OFF;
	logic [4:0] ADDRESS;
	logic [31:0] WRITEDATA, READDATA, rd, r, seed;
	logic [7:0] ANT_CODE, floor_lvl, res, ask;
	logic slow;
	amd_adc_t ADC_RESULT;
	logic [63:0] exp_q[$];
	int n_errors, comparisons, htg, hc;
	amd_calib u_amd_calib (.CORE_CLK(CORE_CLK), .RST(RST), .ADDRESS(ADDRESS), .READ(READ),
		.WRITE(WRITE), .WRITEDATA(WRITEDATA), .READDATA(READDATA), .WAITREQUEST(WAITREQUEST),
		.ADC_START(ADC_START), .ADC_RESULT(ADC_RESULT), .MOD_REQ(MOD_REQ),
		.TX_ENABLE(TX_ENABLE), .ANT_CODE(ANT_CODE), .ANT_OOK_OFF(ANT_OOK_OFF));
	amd_adc_model u_amd_adc_model (.clk(CORE_CLK), .rst(RST), .start(ADC_START),
		.code(ANT_CODE), .slow(slow), .floor_lvl(floor_lvl), .result(ADC_RESULT));
	initial begin
		CORE_CLK = 1'b0;
		forever #5 CORE_CLK = ~CORE_CLK;
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic int lvl(input int c, input int f);
		return (200 - 4 * c < f) ? f : 200 - 4 * c;
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		comparisons++;
		if (seen !== want) begin
			n_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask
	// watcher: oldest note is judged against each completed read
	always @(posedge CORE_CLK) begin
		if (READ === 1'b1 && WAITREQUEST === 1'b0 && exp_q.size() > 0) begin
			check(READDATA & exp_q[0][63:32], exp_q[0][31:0]);
			void'(exp_q.pop_front());
		end
	end
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
		input logic [31:0] m);
		int n;
		n = 0;
		if (!wr) exp_q.push_back({m, d});
		ADDRESS <= a;
		WRITEDATA <= wr ? d : 32'h0;
		READ <= !wr;
		WRITE <= wr;
		@(posedge CORE_CLK);
		while (WAITREQUEST !== 1'b0 && n < 50) begin
			@(posedge CORE_CLK);
			n++;
		end
		if (n == 50) n_errors++;
		rd = READDATA;
		READ <= 1'b0;
		WRITE <= 1'b0;
		@(posedge CORE_CLK);
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 32'h0);
	endtask
	task automatic rdx(input logic [4:0] a, input logic [31:0] e);
		bus(1'b0, a, e, 32'hffffffff);
	endtask
	task automatic wait_idle();
		int n;
		n = 0;
		do begin
			bus(1'b0, `AMD_OFF_STATUS, 32'h0, 32'h0);
			n++;
		end while (rd[0] !== 1'b0 && n < 2000);
		// a sequencer that never goes idle counts as a mismatch
		if (rd[0] !== 1'b0) n_errors++;
	endtask
	task automatic calib(input logic [5:0] fr, input logic [7:0] nm, input logic [7:0] fl);
		int tg, c;
		floor_lvl <= fl;
		slow <= ~slow;
		wr(`AMD_OFF_NOMOD_LEVEL, 32'(nm));
		wr(`AMD_OFF_TARGET, {24'h0, 1'b0, fr, 1'b0});
		wr(`AMD_OFF_CMD, 32'h1);
		repeat (3) @(posedge CORE_CLK);
		check(32'(TX_ENABLE), 32'h1);
		wait_idle();
		tg = (lvl(nm, fl) * 64) / (64 + fr);
		c = nm;
		do c++; while (c < 255 && lvl(c, fl) > tg);
		res = 8'(c);
		rdx(`AMD_OFF_RESULT, 32'(c));
		rdx(`AMD_OFF_ADC, 32'(lvl(c, fl)));
		rdx(`AMD_OFF_STATUS, {29'h0, fr > 6'h37, lvl(c, fl) > tg, 1'b0});
		check(32'(ANT_CODE), 32'(nm));
	endtask
	task automatic results();
		$display("comparisons %0d n_errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial begin
		#600000;
		n_errors++;
		results();
	end
	initial begin
		{RST, READ, WRITE, MOD_REQ, slow, ADDRESS, WRITEDATA} = {1'b1, 41'h0};
		{floor_lvl, n_errors, comparisons, seed} = {8'h0, 64'h0, 32'd49};
		repeat (10) @(posedge CORE_CLK);
		RST <= 1'b0;
		@(posedge CORE_CLK);
		for (int a = 0; a <= 16; a += 4) rdx(5'(a), 32'h0);
		r = rnd();
		ask = r[7:0];
		wr(`AMD_OFF_ASK_LEVEL, r);
		rdx(`AMD_OFF_ASK_LEVEL, 32'(ask));
		wr(`AMD_OFF_MODE, 32'hff);
		rdx(`AMD_OFF_MODE, 32'h0f);
		wr(5'h02, 32'hff);
		rdx(5'h02, 32'h0);
		r = rnd();
		calib(6'h37, 8'(r[3:0]), 8'h0);
		calib(r[21:16], 8'(r[11:8]), 8'h0);
		calib(6'h20, 8'(r[27:24]), 8'h0);
		// on-off keying outside ASK modes, host or calibrated keyed level inside
		for (int s = 0; s < 2; s++) begin
			wr(`AMD_OFF_TARGET, {24'h0, 1'(s), 6'h20, 1'b0});
			for (int md = 0; md < 8; md++) begin
				wr(`AMD_OFF_MODE, 32'(md));
				MOD_REQ <= 1'b1;
				repeat (2) @(posedge CORE_CLK);
				check(32'(ANT_OOK_OFF), 32'(!(md[0] | (md[1] & md[2]))));
				if (md[0] | (md[1] & md[2])) check(32'(ANT_CODE), s ? 32'(ask) : 32'(res));
				MOD_REQ <= 1'b0;
				@(posedge CORE_CLK);
			end
		end
		wr(`AMD_OFF_NOMOD_LEVEL, 32'h0);
		wr(`AMD_OFF_MODE, 32'h8);
		wr(`AMD_OFF_CMD, 32'h2);
		wait_idle();
		rdx(`AMD_OFF_ADC, 32'(lvl(0, 0)));
		check(32'(TX_ENABLE), 32'h1);
		// host-run loop: step the unmodulated level, then hand the best code over
		htg = (lvl(0, 0) * 64) / 96;
		hc = 0;
		while (lvl(hc, 0) > htg) begin
			hc++;
			wr(`AMD_OFF_NOMOD_LEVEL, 32'(hc));
			wr(`AMD_OFF_CMD, 32'h2);
			wait_idle();
			rdx(`AMD_OFF_ADC, 32'(lvl(hc, 0)));
		end
		wr(`AMD_OFF_ASK_LEVEL, 32'(hc));
		wr(`AMD_OFF_NOMOD_LEVEL, 32'h0);
		wr(`AMD_OFF_TARGET, 32'h80);
		wr(`AMD_OFF_MODE, 32'h9);
		MOD_REQ <= 1'b1;
		repeat (2) @(posedge CORE_CLK);
		check(32'(ANT_CODE), 32'(hc));
		MOD_REQ <= 1'b0;
		@(posedge CORE_CLK);
		wr(`AMD_OFF_MODE, 32'h0);
		calib(6'h20, 8'hf0, 8'hff);
		results();
	end
endmodule // tb_amd_calib
